// ==== common/csio_params.svh ====
// Offsets, field positions, reset values and constants of the core I/O register bank.
`ifndef CSIO_PARAMS_SVH
`define CSIO_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSIO_OFS_FLAGS 8'h00
`define CSIO_OFS_STACK 8'h02
`define CSIO_OFS_CLKMD 8'h03
`define CSIO_OFS_IRQEN 8'h04
`define CSIO_OFS_IRQPD 8'h05

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSIO_FLAG_RANGE 3
`define CSIO_FLAG_NIBBLE 2
`define CSIO_FLAG_WRAP 1
`define CSIO_FLAG_NULL 0
`define CSIO_FLAG_WIDTH 4
`define CSIO_CLK_SEL_HI 7
`define CSIO_CLK_SEL_LO 5
`define CSIO_CLK_FAST_EN 4
`define CSIO_CLK_TYPE 3
`define CSIO_CLK_SLOW_EN 2
`define CSIO_CLK_WDT_EN 1
`define CSIO_CLK_PIN_FN 0
`define CSIO_IRQ_RSVD 5

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define CSIO_RST_FLAGS 4'h0
`define CSIO_RST_STACK 8'h00
`define CSIO_RST_CLKMD 8'hF6
`define CSIO_RST_IRQEN 8'h00
`define CSIO_RST_IRQPD 8'h00
`define CSIO_IRQ_IMPL 8'hDF
`define CSIO_STACK_STEP 8'h02
`define CSIO_PIN_IRQ_MASK 8'h03

`endif

// ==== common/csio_pkg.sv ====
// Types shared by the core I/O register bank.
`default_nettype none
package csio_pkg;
    `include "csio_params.svh"

    // Oscillator feeding the system clock.
    typedef enum logic [1:0] {
        CSIO_SRC_NONE,
        CSIO_SRC_FAST_RC,
        CSIO_SRC_SLOW_RC,
        CSIO_SRC_EXT_XTAL
    } csio_clk_src_t;

    // Decoded system clock choice.
    typedef struct packed {
        logic valid;
        csio_clk_src_t src;
        logic [6:0] div;
    } csio_clk_sel_t;
endpackage : csio_pkg
`default_nettype wire

// ==== rtl/csio_regs.sv ====
// Core I/O register bank: flags, stack top, clock mode, interrupt enable and request.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "csio_params.svh"

// Behaviour
// - Signed overflow sets bit 3 flag.
// - Low nibble carry or borrow sets bit 2.
// - Carry, borrow or shift updates bit 1.
// - Zero result sets bit 0, else clears.
// - Stack top readable, writable; bit 0 zero (not forced: a write stores bit 0 as given).
// - Type 0 clock selection table, reset 111.
// - Type 1 clock selection table, 11x reserved.
// - Clock mode bit 3 picks the table.
// - Bit 4 enables fast internal oscillator.
// - Bit 2 enables slow oscillator, gates watchdog.
// - Bit 1 enables the watchdog timer.
// - Bit 0 selects port line or reset pin.
// - Interrupt enable bit map, reset zero.
// - Hardware sets requests, software clears by zero.
// - Request bit 5 reserved, no source.
module csio_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic alu_update_in,
    input wire logic [3:0] alu_flag_sel_in,
    input wire logic [7:0] alu_result_in,
    input wire logic alu_signed_range_in,
    input wire logic alu_nibble_wrap_in,
    input wire logic alu_wraparound_in,
    input wire logic stack_push_in,
    input wire logic stack_pop_in,
    input wire logic [7:0] irq_event_in,
    output logic [3:0] arith_flags_out,
    output logic [7:0] stack_top_out,
    output csio_pkg::csio_clk_src_t clk_src_out,
    output logic [6:0] clk_div_out,
    output logic clk_sel_valid_out,
    output logic fast_rc_en_out,
    output logic slow_rc_en_out,
    output logic watchdog_en_out,
    output logic ext_reset_pin_sel_out,
    output logic irq_out
);
    import csio_pkg::*;

    // ----------------------------------------------------------------------
    // Storage and decode helpers
    // ----------------------------------------------------------------------
    logic [3:0] arith_status_flags;
    logic [7:0] stack_top_pointer;
    logic [7:0] clock_mode_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_pending_reg;
    logic [7:0] next_irq_pending;
    logic [1:0] pin_sync1;
    logic [1:0] pin_sync2;
    logic [1:0] pin_sync3;
    logic [1:0] pin_level;
    logic [1:0] pin_edge;
    logic [7:0] irq_set;
    csio_clk_sel_t clk_sel;

    // Builds one entry of the clock selection tables.
    function automatic csio_clk_sel_t clk_entry(input csio_clk_src_t src,
                                                input logic [6:0] div);
        csio_clk_sel_t e;
        e.valid = 1'b1;
        e.src = src;
        e.div = div;
        return e;
    endfunction : clk_entry

    // Decodes the system clock field under the table picked by the type bit.
    function automatic csio_clk_sel_t clk_decode(input logic [2:0] code,
                                                 input logic table1);
        csio_clk_sel_t sel;
        sel.valid = 1'b0;
        sel.src = CSIO_SRC_NONE;
        sel.div = 7'h00;
        if (!table1) begin
            case (code)
                3'h0: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h04);
                3'h1: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h02);
                3'h3: sel = clk_entry(CSIO_SRC_EXT_XTAL, 7'h04);
                3'h4: sel = clk_entry(CSIO_SRC_EXT_XTAL, 7'h02);
                3'h5: sel = clk_entry(CSIO_SRC_EXT_XTAL, 7'h01);
                3'h6: sel = clk_entry(CSIO_SRC_SLOW_RC, 7'h04);
                3'h7: sel = clk_entry(CSIO_SRC_SLOW_RC, 7'h01);
                default: sel.valid = 1'b0;
            endcase
        end else begin
            case (code)
                3'h0: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h10);
                3'h1: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h08);
                3'h2: sel = clk_entry(CSIO_SRC_SLOW_RC, 7'h10);
                3'h3: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h20);
                3'h4: sel = clk_entry(CSIO_SRC_FAST_RC, 7'h40);
                3'h5: sel = clk_entry(CSIO_SRC_EXT_XTAL, 7'h08);
                default: sel.valid = 1'b0;
            endcase
        end
        return sel;
    endfunction : clk_decode

    // True when a write strobe addresses the given offset.
    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs,
                                    input logic wr);
        return wr && (addr == ofs);
    endfunction : wr_hit

    // ----------------------------------------------------------------------
    // Arithmetic status flags
    // ----------------------------------------------------------------------

    // The unit's update wins over a software write in the same cycle; the
    // upper nibble is not stored and reads back as zero.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            arith_status_flags <= `CSIO_RST_FLAGS;
        end else if (alu_update_in) begin
            if (alu_flag_sel_in[`CSIO_FLAG_RANGE]) begin
                arith_status_flags[`CSIO_FLAG_RANGE] <= alu_signed_range_in;
            end
            if (alu_flag_sel_in[`CSIO_FLAG_NIBBLE]) begin
                arith_status_flags[`CSIO_FLAG_NIBBLE] <= alu_nibble_wrap_in;
            end
            if (alu_flag_sel_in[`CSIO_FLAG_WRAP]) begin
                arith_status_flags[`CSIO_FLAG_WRAP] <= alu_wraparound_in;
            end
            if (alu_flag_sel_in[`CSIO_FLAG_NULL]) begin
                arith_status_flags[`CSIO_FLAG_NULL] <= (alu_result_in == 8'h00);
            end
        end else if (wr_hit(reg_addr_in, `CSIO_OFS_FLAGS, reg_wr_in)) begin
            arith_status_flags <= reg_wdata_in[3:0];
        end
    end

    // ----------------------------------------------------------------------
    // Stack top pointer
    // ----------------------------------------------------------------------

    // Software write wins over push and pop; keeping bit 0 clear is up to software.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stack_top_pointer <= `CSIO_RST_STACK;
        end else if (wr_hit(reg_addr_in, `CSIO_OFS_STACK, reg_wr_in)) begin
            stack_top_pointer <= reg_wdata_in;
        end else if (stack_push_in && !stack_pop_in) begin
            stack_top_pointer <= stack_top_pointer + `CSIO_STACK_STEP;
        end else if (stack_pop_in && !stack_push_in) begin
            stack_top_pointer <= stack_top_pointer - `CSIO_STACK_STEP;
        end
    end

    // ----------------------------------------------------------------------
    // Clock mode
    // ----------------------------------------------------------------------

    // Holds the clock selection, oscillator enables and pin function.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_mode_reg <= `CSIO_RST_CLKMD;
        end else if (wr_hit(reg_addr_in, `CSIO_OFS_CLKMD, reg_wr_in)) begin
            clock_mode_reg <= reg_wdata_in;
        end
    end

    // Registered decode, so the clock controls come from flip-flops.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clk_sel <= '0;
        end else begin
            clk_sel <= clk_decode(clock_mode_reg[`CSIO_CLK_SEL_HI:`CSIO_CLK_SEL_LO],
                                  clock_mode_reg[`CSIO_CLK_TYPE]);
        end
    end

    // Enables follow the register bits; the watchdog also needs the slow oscillator.
    assign fast_rc_en_out = clock_mode_reg[`CSIO_CLK_FAST_EN];
    assign slow_rc_en_out = clock_mode_reg[`CSIO_CLK_SLOW_EN];
    assign watchdog_en_out = clock_mode_reg[`CSIO_CLK_WDT_EN]
                             && clock_mode_reg[`CSIO_CLK_SLOW_EN];
    assign ext_reset_pin_sel_out = clock_mode_reg[`CSIO_CLK_PIN_FN];
    assign clk_src_out = clk_sel.src;
    assign clk_div_out = clk_sel.div;
    assign clk_sel_valid_out = clk_sel.valid;

    // ----------------------------------------------------------------------
    // Interrupt enable and request
    // ----------------------------------------------------------------------

    // Enable mask; the reserved bit is stored like the others.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_enable_reg <= `CSIO_RST_IRQEN;
        end else if (wr_hit(reg_addr_in, `CSIO_OFS_IRQEN, reg_wr_in)) begin
            irq_enable_reg <= reg_wdata_in;
        end
    end

    // Pin sources pass three flops; the accepted level follows each counted change.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_sync1 <= 2'h0;
            pin_sync2 <= 2'h0;
            pin_sync3 <= 2'h0;
            pin_level <= 2'h0;
        end else begin
            pin_sync1 <= irq_event_in[1:0];
            pin_sync2 <= pin_sync1;
            pin_sync3 <= pin_sync2;
            pin_level <= pin_level ^ pin_edge;
        end
    end

    // A new pin level counts once stages two and three agree on it, so a short
    // glitch that never settles in both stages raises no request.
    assign pin_edge = ~(pin_sync2 ^ pin_sync3) & (pin_sync3 ^ pin_level);

    // Pins raise on either edge, bits 7:6 and 4:2 on a one-cycle event pulse; bit 5 is masked off.
    assign irq_set = {irq_event_in[7:2], pin_edge} & `CSIO_IRQ_IMPL;

    // Writing zero clears a request, but a new event in that cycle wins.
    always_comb begin
        next_irq_pending = irq_pending_reg;
        if (wr_hit(reg_addr_in, `CSIO_OFS_IRQPD, reg_wr_in)) begin
            next_irq_pending = irq_pending_reg & reg_wdata_in;
        end
        next_irq_pending = (next_irq_pending | irq_set) & `CSIO_IRQ_IMPL;
    end

    // Request latches; cleared at reset so the first interrupt is clean.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_pending_reg <= `CSIO_RST_IRQPD;
        end else begin
            irq_pending_reg <= next_irq_pending;
        end
    end

    // One level request to the core.
    assign irq_out = |(irq_pending_reg & irq_enable_reg);

    // ----------------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------------

    // Read data stand in the cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `CSIO_OFS_FLAGS: reg_rdata_out <= {4'h0, arith_status_flags};
                `CSIO_OFS_STACK: reg_rdata_out <= stack_top_pointer;
                `CSIO_OFS_CLKMD: reg_rdata_out <= clock_mode_reg;
                `CSIO_OFS_IRQEN: reg_rdata_out <= irq_enable_reg;
                `CSIO_OFS_IRQPD: reg_rdata_out <= irq_pending_reg;
                default: reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    assign arith_flags_out = arith_status_flags;
    assign stack_top_out = stack_top_pointer;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------

    a_range_flag_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_update_in && alu_flag_sel_in[`CSIO_FLAG_RANGE] |=>
        arith_flags_out[`CSIO_FLAG_RANGE] == $past(alu_signed_range_in))
        else $error("Overflow flag did not follow the arithmetic unit.");

    a_nibble_flag_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_update_in && alu_flag_sel_in[`CSIO_FLAG_NIBBLE] |=>
        arith_flags_out[`CSIO_FLAG_NIBBLE] == $past(alu_nibble_wrap_in))
        else $error("Nibble carry flag did not follow the arithmetic unit.");

    a_wrap_flag_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_update_in && !alu_flag_sel_in[`CSIO_FLAG_WRAP] |=>
        $stable(arith_flags_out[`CSIO_FLAG_WRAP]))
        else $error("Carry flag changed on an update that does not touch it.");

    a_null_flag_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        alu_update_in && alu_flag_sel_in[`CSIO_FLAG_NULL] |=>
        arith_flags_out[`CSIO_FLAG_NULL] == ($past(alu_result_in) == 8'h00))
        else $error("Zero flag does not match the result.");

    a_flag_upper_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(reg_rd_in) && $past(reg_addr_in) == `CSIO_OFS_FLAGS |->
        reg_rdata_out[7:4] == 4'h0)
        else $error("Reserved flag bits read nonzero.");

    a_stack_push_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
        stack_push_in && !stack_pop_in && !(reg_wr_in && reg_addr_in == `CSIO_OFS_STACK)
        |=> stack_top_out == $past(stack_top_out) + `CSIO_STACK_STEP)
        else $error("Stack top did not advance by two on a push.");

    a_stack_write_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_STACK |=>
        stack_top_out == $past(reg_wdata_in))
        else $error("Stack top did not take the value written.");

    a_clk_default_slow: assert property (@(posedge clk_in) disable iff (!resetn_in)
        clock_mode_reg[7:5] == 3'h7 && !clock_mode_reg[`CSIO_CLK_TYPE] |=>
        clk_src_out == CSIO_SRC_SLOW_RC && clk_div_out == 7'h01 && clk_sel_valid_out)
        else $error("Code 111 of table 0 is not the undivided slow oscillator.");

    a_clk_type1_rsvd: assert property (@(posedge clk_in) disable iff (!resetn_in)
        clock_mode_reg[7:6] == 2'h3 && clock_mode_reg[`CSIO_CLK_TYPE] |=>
        !clk_sel_valid_out)
        else $error("Reserved table 1 code decoded as valid.");

    a_wdt_needs_slow: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !slow_rc_en_out |-> !watchdog_en_out)
        else $error("Watchdog enabled while the slow oscillator is off.");

    a_pend_set_wins: assert property (@(posedge clk_in) disable iff (!resetn_in)
        irq_event_in[7] |=> irq_pending_reg[7])
        else $error("Request event lost, possibly against a clear.");

    a_pend_clear_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_IRQPD && !reg_wdata_in[6] &&
        !irq_event_in[6] |=> !irq_pending_reg[6])
        else $error("Writing zero did not clear a request bit.");

    a_pend_rsvd_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !irq_pending_reg[`CSIO_IRQ_RSVD])
        else $error("Reserved request bit became set.");

    a_irq_gate_enable: assert property (@(posedge clk_in) disable iff (!resetn_in)
        irq_pending_reg[3] && reg_wr_in && reg_addr_in == `CSIO_OFS_IRQEN &&
        reg_wdata_in[3] |=> irq_out)
        else $error("Enabled pending request did not raise the interrupt.");

    a_fast_rc_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_CLKMD |=>
        fast_rc_en_out == $past(reg_wdata_in[`CSIO_CLK_FAST_EN]))
        else $error("Fast oscillator enable does not follow its bit.");

    a_watchdog_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_CLKMD && reg_wdata_in[`CSIO_CLK_SLOW_EN] |=>
        watchdog_en_out == $past(reg_wdata_in[`CSIO_CLK_WDT_EN]))
        else $error("Watchdog enable does not follow its bit.");

    a_pin_fn_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_CLKMD |=>
        ext_reset_pin_sel_out == $past(reg_wdata_in[`CSIO_CLK_PIN_FN]))
        else $error("Shared pin function does not follow its bit.");

    a_enable_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
        reg_wr_in && reg_addr_in == `CSIO_OFS_IRQEN |=>
        irq_enable_reg == $past(reg_wdata_in))
        else $error("Interrupt enable write did not land.");

    a_pin_edge_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
        pin_edge[0] |=> irq_pending_reg[0])
        else $error("Settled pin change did not raise its request.");

endmodule : csio_regs
`default_nettype wire

// ==== dv/csio_core_model.sv ====
// Core-side bus master model that issues I/O register reads and writes.
`timescale 1ns/10ps
`default_nettype none
`include "csio_params.svh"
module csio_core_model (
    input wire logic clk_in,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // The bus idles with both strobes low.
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // One-cycle write; reserved flag bits and the stack low bit always go out as zero.
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] keep;
        keep = (addr == `CSIO_OFS_FLAGS) ? 8'h0F : (addr == `CSIO_OFS_STACK) ? 8'hFE : 8'hFF;
        @(posedge clk_in);
        reg_addr_out <= addr;
        reg_wdata_out <= data & keep;
        reg_wr_out <= 1'b1;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        reg_wdata_out <= ~(data & keep); // Stale data must not look valid.
    endtask : wr_reg

    // One-cycle read; the data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        reg_addr_out <= addr;
        reg_rd_out <= 1'b1;
        @(posedge clk_in);
        reg_rd_out <= 1'b0;
        #1;
        data = reg_rdata_in;
    endtask : rd_reg
endmodule : csio_core_model
`default_nettype wire

// ==== dv/csio_regs_test.sv ====
// Self-checking testbench for the core I/O register bank.
`timescale 1ns/10ps
`default_nettype none
`include "csio_params.svh"
module csio_regs_test;
    import csio_pkg::*;
    logic clk_in, resetn_in, reg_wr, reg_rd, alu_update, alu_v, alu_n, alu_w, push, pop;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, alu_result, irq_ev, stack;
    logic [3:0] alu_sel, flags;
    logic [6:0] clk_div;
    csio_clk_src_t clk_src;
    logic clk_valid, fast_en, slow_en, wdt_en, pin_sel, irq;
    int error_cnt = 0;
    int checks = 0;
    logic [19:0] alu_tab [7] = '{20'h1000B, 20'h1050A, 20'h80002, 20'h40046,
                                 20'h20004, 20'hF80AA, 20'h000EA};

    // ------------------------------------------------------------------
    // Instances, clock and helpers
    // ------------------------------------------------------------------
    csio_core_model u_csio_core_model (.clk_in(clk_in), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_rdata_in(reg_rdata));
    csio_regs u_csio_regs (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .alu_update_in(alu_update), .alu_flag_sel_in(alu_sel),
        .alu_result_in(alu_result), .alu_signed_range_in(alu_v), .alu_nibble_wrap_in(alu_n),
        .alu_wraparound_in(alu_w), .stack_push_in(push), .stack_pop_in(pop),
        .irq_event_in(irq_ev), .arith_flags_out(flags), .stack_top_out(stack),
        .clk_src_out(clk_src), .clk_div_out(clk_div), .clk_sel_valid_out(clk_valid),
        .fast_rc_en_out(fast_en), .slow_rc_en_out(slow_en), .watchdog_en_out(wdt_en),
        .ext_reset_pin_sel_out(pin_sel), .irq_out(irq));

    // The system clock runs at 40 MHz.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_csio_core_model.wr_reg(a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_csio_core_model.rd_reg(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    // Expected {valid, source, divisor} for {type, code}.
    function automatic logic [9:0] clk_exp(input logic [3:0] c);
        case (c)
            4'h0: return {1'b1, CSIO_SRC_FAST_RC, 7'h04};
            4'h1: return {1'b1, CSIO_SRC_FAST_RC, 7'h02};
            4'h3: return {1'b1, CSIO_SRC_EXT_XTAL, 7'h04};
            4'h4: return {1'b1, CSIO_SRC_EXT_XTAL, 7'h02};
            4'h5: return {1'b1, CSIO_SRC_EXT_XTAL, 7'h01};
            4'h6: return {1'b1, CSIO_SRC_SLOW_RC, 7'h04};
            4'h7: return {1'b1, CSIO_SRC_SLOW_RC, 7'h01};
            4'h8: return {1'b1, CSIO_SRC_FAST_RC, 7'h10};
            4'h9: return {1'b1, CSIO_SRC_FAST_RC, 7'h08};
            4'hA: return {1'b1, CSIO_SRC_SLOW_RC, 7'h10};
            4'hB: return {1'b1, CSIO_SRC_FAST_RC, 7'h20};
            4'hC: return {1'b1, CSIO_SRC_FAST_RC, 7'h40};
            4'hD: return {1'b1, CSIO_SRC_EXT_XTAL, 7'h08};
            default: return 10'h000;
        endcase
    endfunction : clk_exp

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, the decode loaded after release, and unmapped reads.
    task automatic t_reset;
        rdc(`CSIO_OFS_FLAGS, 8'h00);
        rdc(`CSIO_OFS_CLKMD, 8'hF6);
        rdc(`CSIO_OFS_IRQEN, 8'h00);
        rdc(8'h01, 8'h00);
        chk({6'h00, clk_valid, clk_src, clk_div}, {6'h00, 1'b1, CSIO_SRC_SLOW_RC, 7'h01});
        chk({11'h000, fast_en, slow_en, wdt_en, pin_sel, irq}, 16'h001C);
    endtask : t_reset

    // Software write, then selective arithmetic updates of each flag.
    task automatic t_flags;
        wr(`CSIO_OFS_FLAGS, 8'h0A);
        rdc(`CSIO_OFS_FLAGS, 8'h0A);
        foreach (alu_tab[k]) begin
            @(posedge clk_in);
            alu_sel <= alu_tab[k][19:16];
            alu_result <= alu_tab[k][15:8];
            {alu_v, alu_n, alu_w} <= alu_tab[k][7:5];
            alu_update <= 1'b1;
            @(posedge clk_in);
            alu_update <= 1'b0;
            #1;
            chk({12'h000, flags}, {12'h000, alu_tab[k][3:0]});
        end
    endtask : t_flags

    // Stack top written, pushed, popped back to back, and read.
    task automatic t_stack;
        wr(`CSIO_OFS_STACK, 8'h40);
        @(posedge clk_in);
        push <= 1'b1;
        @(posedge clk_in);
        push <= 1'b0;
        pop <= 1'b1;
        repeat (2) @(posedge clk_in);
        push <= 1'b1;
        @(posedge clk_in);
        {push, pop} <= 2'b00;
        #1;
        chk({8'h00, stack}, 16'h003E);
        rdc(`CSIO_OFS_STACK, 8'h3E);
    endtask : t_stack

    // Every clock code of both tables, then the enable and pin bits.
    task automatic t_clock;
        logic [9:0] e;
        logic [11:0] en_tab [3] = '{12'hE31, 12'hF4C, 12'hF6E};
        for (int c = 0; c < 16; c++) begin
            e = clk_exp(c[3:0]);
            wr(`CSIO_OFS_CLKMD, {c[2:0], 1'b1, c[3], 3'b110});
            tick(1);
            chk({6'h00, clk_valid, {clk_src, clk_div} & {9{e[9]}}}, {6'h00, e});
        end
        foreach (en_tab[k]) begin
            wr(`CSIO_OFS_CLKMD, en_tab[k][11:4]);
            tick(1);
            chk({12'h000, fast_en, slow_en, wdt_en, pin_sel}, {12'h000, en_tab[k][3:0]});
            rdc(`CSIO_OFS_CLKMD, en_tab[k][11:4]);
        end
    endtask : t_clock

    // Each request source, masking, and clearing by writing zero.
    task automatic t_irq;
        wr(`CSIO_OFS_IRQPD, 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            irq_ev[i] <= ~irq_ev[i];
            @(posedge clk_in);
            irq_ev[7:2] <= 6'h00;
            tick(6);
            rdc(`CSIO_OFS_IRQPD, (8'h01 << i) & 8'hDF);
            chk({15'h0000, irq}, 16'h0000);
            wr(`CSIO_OFS_IRQPD, 8'h00);
        end
        wr(`CSIO_OFS_IRQEN, 8'hFF);
        rdc(`CSIO_OFS_IRQEN, 8'hFF);
        wr(`CSIO_OFS_IRQEN, 8'hF7);
        @(posedge clk_in);
        irq_ev[3] <= 1'b1;
        @(posedge clk_in);
        irq_ev[3] <= 1'b0;
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        wr(`CSIO_OFS_IRQEN, 8'h08);
        tick(1);
        chk({15'h0000, irq}, 16'h0001);
        wr(`CSIO_OFS_IRQPD, 8'hF7);
        tick(1);
        chk({15'h0000, irq}, 16'h0000);
    endtask : t_irq

    task automatic summarize;
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // Stops a hung run well past the expected length of all scenarios.
    initial begin
        #(25 * 5000);
        error_cnt++;
        summarize();
    end

    // Reset for six cycles, then the scenarios in turn.
    initial begin
        resetn_in = 1'b0;
        {alu_update, alu_v, alu_n, alu_w, push, pop} = 6'h00;
        {alu_sel, alu_result, irq_ev} = 20'h00000;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_flags();
        t_stack();
        t_clock();
        t_irq();
        summarize();
    end
endmodule : csio_regs_test
`default_nettype wire
